// File: cise_alu.sv
`timescale 1ns/1ps
`include "cise_consts.svh"
module cise_alu (
   cise_exec_if.alu x
);
   logic to_file;

   // both increment forms share one adder
   function automatic logic [`CISE_DATA_W-1:0] bump_up(input logic [`CISE_DATA_W-1:0] v);
      bump_up = v + `CISE_STEP;
   endfunction : bump_up

   assign to_file = (x.dest == `CISE_DEST_FILE);

   always_comb begin
      x.result   = `CISE_CLR_VAL;
      x.wr_acc   = 1'b0;
      x.wr_file  = 1'b0;
      x.zero_en  = 1'b0;
      x.skip     = 1'b0;
      x.jump     = 1'b0;
      unique case (x.op)
         cise_pkg::OP_NOP: begin
         end
         cise_pkg::OP_CLR_ACC: begin
            x.result  = `CISE_CLR_VAL;
            x.wr_acc  = 1'b1;
            x.zero_en = 1'b1;
         end
         cise_pkg::OP_DEC_SKZ: begin
            x.result  = x.file_val - `CISE_STEP;
            x.wr_acc  = !to_file;
            x.wr_file = to_file;
            x.skip    = cise_pkg::cise_is_zero(x.result);
         end
         cise_pkg::OP_INC_SKZ: begin
            x.result  = bump_up(x.file_val);
            x.wr_acc  = !to_file;
            x.wr_file = to_file;
            x.skip    = cise_pkg::cise_is_zero(x.result);
         end
         cise_pkg::OP_JUMP: begin
            x.jump = 1'b1;
         end
         cise_pkg::OP_OR_LIT: begin
            x.result  = x.acc_val | x.literal[`CISE_LIT8_HI:0];
            x.wr_acc  = 1'b1;
            x.zero_en = 1'b1;
         end
         cise_pkg::OP_INC_F: begin
            x.result  = bump_up(x.file_val);
            x.wr_acc  = !to_file;
            x.wr_file = to_file;
            x.zero_en = 1'b1;
         end
         default: begin
         end
      endcase
   end

   assign x.zero_val = cise_pkg::cise_is_zero(x.result);
endmodule : cise_alu

// File: cise_consts.svh
`ifndef CISE_CONSTS_SVH
`define CISE_CONSTS_SVH
// Overview of operation
// - clear_accumulator loads 00h into accumulator and sets zero_flag.
// - decrement_skip_if_zero subtracts one from file register; destination_select picks target.
// - decrement result zero discards next instruction, two cycles; flags untouched.
// - increment_skip_if_zero adds one, routes by destination_select, skips on zero result.
// - increment_file_register adds one, routes by destination_select, updates zero_flag, never skips.
// - unconditional_jump loads 11-bit literal into pc bits 10:0, two cycles.
// - unconditional_jump fills pc bits 14:11 from upper latch bits 6:3.
// - or_literal_into_accumulator ORs 8-bit literal into accumulator, updates zero_flag.

// ====================================================
// widths and sizes
`define CISE_DATA_W      8
`define CISE_PC_W        15
`define CISE_FADDR_W     7
`define CISE_FILE_DEPTH  128
`define CISE_LIT_W       11
`define CISE_LATCH_W     7
`define CISE_OP_W        3
// ====================================================
// field positions
`define CISE_JUMP_LO_HI  10
`define CISE_PC_UP_HI    14
`define CISE_PC_UP_LO    11
`define CISE_LATCH_HI    6
`define CISE_LATCH_LO    3
`define CISE_LIT8_HI     7
// ====================================================
// values
`define CISE_ACC_RST     8'h00
`define CISE_FILE_RST    8'h00
`define CISE_ZERO_RST    1'b0
`define CISE_PC_RST      15'h0000
`define CISE_CLR_VAL     8'h00
`define CISE_STEP        8'h01
`define CISE_PC_NEXT     15'h0001
`define CISE_PC_SKIP     15'h0002
// destination_select: 0 accumulator, 1 file register
`define CISE_DEST_FILE   1'b1
`endif

// File: cise_core.sv
`timescale 1ns/1ps
`include "cise_consts.svh"
module cise_core (
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     srst,
   // instruction presented for execution
   input  wire logic                     instr_valid,
   input  wire logic [`CISE_OP_W-1:0]    instr_op,
   input  wire logic [`CISE_FADDR_W-1:0] instr_file_addr,
   input  wire logic                     instr_dest,
   input  wire logic [`CISE_LIT_W-1:0]   instr_literal,
   // upper bits source for jumps
   input  wire logic [`CISE_LATCH_W-1:0] program_counter_upper_latch,
   // file register observation
   input  wire logic [`CISE_FADDR_W-1:0] peek_addr,
   output logic [`CISE_DATA_W-1:0]       peek_data,
   // core state
   output logic [`CISE_DATA_W-1:0]       acc,
   output logic                          zero_flag,
   output logic [`CISE_PC_W-1:0]         program_counter,
   output logic                          busy,
   output logic                          retire
);
   // ====================================================
   // state
   logic [`CISE_DATA_W-1:0]   file_q [`CISE_FILE_DEPTH];
   logic [`CISE_DATA_W-1:0]   acc_q;
   logic                      zero_q;
   logic [`CISE_PC_W-1:0]     pc_q;
   logic                      retire_q;
   logic                      busy_q;
   logic [`CISE_DATA_W-1:0]   peek_q;
   cise_pkg::cise_state_t     state_q;
   logic                      take;

   // ====================================================
   // helpers
   // skip steps over the discarded word
   function automatic logic [`CISE_PC_W-1:0] pc_advance(input logic [`CISE_PC_W-1:0] pc,
                                                       input logic                   skip);
      pc_advance = skip ? pc + `CISE_PC_SKIP : pc + `CISE_PC_NEXT;
   endfunction : pc_advance

   cise_exec_if ex ();

   // an instruction presented in the flush cycle is the discarded one
   assign take = instr_valid && (state_q == cise_pkg::ST_EXEC);

   assign ex.op       = take ? cise_pkg::cise_op_t'(instr_op) : cise_pkg::OP_NOP;
   assign ex.file_val = file_q[instr_file_addr];
   assign ex.acc_val  = acc_q;
   assign ex.literal  = instr_literal;
   assign ex.dest     = instr_dest;

   cise_alu u_alu (
      .x (ex)
   );

   // ====================================================
   // sequencing
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_q <= cise_pkg::ST_EXEC;
      end else begin
         unique case (state_q)
            cise_pkg::ST_EXEC: begin
               // second cycle for skip or jump
               if (ex.skip || ex.jump) begin
                  state_q <= cise_pkg::ST_FLUSH;
               end
            end
            cise_pkg::ST_FLUSH: begin
               state_q <= cise_pkg::ST_EXEC;
            end
         endcase
      end
   end

   // ====================================================
   // program counter
   always_ff @(posedge mclk) begin
      if (srst) begin
         pc_q <= `CISE_PC_RST;
      end else if (take) begin
         if (ex.jump) begin
            pc_q[`CISE_PC_UP_HI:`CISE_PC_UP_LO] <=
               program_counter_upper_latch[`CISE_LATCH_HI:`CISE_LATCH_LO];
            pc_q[`CISE_JUMP_LO_HI:0] <= instr_literal;
         end else begin
            // step, two words on a skip
            pc_q <= pc_advance(pc_q, ex.skip);
         end
      end
   end

   // ====================================================
   // accumulator and zero flag
   always_ff @(posedge mclk) begin
      if (srst) begin
         acc_q <= `CISE_ACC_RST;
      end else if (ex.wr_acc) begin
         acc_q <= ex.result;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         zero_q <= `CISE_ZERO_RST;
      end else if (ex.zero_en) begin
         zero_q <= ex.zero_val;
      end
   end

   // ====================================================
   // file registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int i = 0; i < `CISE_FILE_DEPTH; i++) begin
            file_q[i] <= `CISE_FILE_RST;
         end
      end else if (ex.wr_file) begin
         file_q[instr_file_addr] <= ex.result;
      end
   end

   // peek shows the array after the previous edge, one cycle late
   always_ff @(posedge mclk) begin
      if (srst) begin
         peek_q <= `CISE_FILE_RST;
      end else begin
         peek_q <= file_q[peek_addr];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         retire_q <= 1'b0;
      end else begin
         retire_q <= take;
      end
   end

   // flush flag
   // own flop so busy leaves the block registered, not decoded
   always_ff @(posedge mclk) begin
      if (srst) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= take && (ex.skip || ex.jump);
      end
   end

   assign peek_data       = peek_q;
   assign acc             = acc_q;
   assign zero_flag       = zero_q;
   assign program_counter = pc_q;
   assign busy            = busy_q;
   assign retire          = retire_q;
endmodule : cise_core

// File: cise_core_assertions.sv
`timescale 1ns/1ps
`include "cise_consts.svh"
module cise_core_assertions (
   // clock and reset
   input wire logic        mclk,
   input wire logic        srst,
   // instruction
   input wire logic        instr_valid,
   input wire logic [2:0]  instr_op,
   input wire logic        instr_dest,
   input wire logic [10:0] instr_literal,
   input wire logic [6:0]  program_counter_upper_latch,
   // core state
   input wire logic [7:0]  acc,
   input wire logic        zero_flag,
   input wire logic [14:0] program_counter,
   input wire logic        busy,
   input wire logic        retire
);
   logic        tk;
   logic [14:0] jpc_q;
   logic [7:0]  orv_q;
   assign tk = instr_valid && !busy;
   // expected values one edge late, so no part-select inside $past
   always_ff @(posedge mclk) jpc_q <= {program_counter_upper_latch[6:3], instr_literal};
   always_ff @(posedge mclk) orv_q <= acc | instr_literal[7:0];
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   sequence s_flush; busy ##1 !busy; endsequence
   property p_clr; tk && instr_op == 3'h1 |=> acc == 8'h00 && zero_flag; endproperty
   property p_jmp; tk && instr_op == 3'h4 |=> program_counter == jpc_q ##0 s_flush; endproperty
   property p_or; tk && instr_op == 3'h5 |=> acc == orv_q && zero_flag == (orv_q == 8'h00); endproperty
   property p_skf; tk && instr_op inside {3'h2, 3'h3} |=> zero_flag == $past(zero_flag); endproperty
   property p_inz; tk && instr_op == 3'h6 && !instr_dest |=> zero_flag == (acc == 8'h00); endproperty
   property p_one; tk && instr_op inside {3'h0, 3'h1, 3'h5, 3'h6, 3'h7}
      |=> program_counter == $past(program_counter) + 15'h0001 && !busy; endproperty
   property p_skp; tk && instr_op inside {3'h2, 3'h3}
      |=> program_counter == $past(program_counter) + (busy ? 15'h0002 : 15'h0001); endproperty
   property p_ret; tk |=> retire; endproperty
   property p_bsy; busy |=> !busy && !retire; endproperty
   a_clr: assert property (p_clr) else $error("clear wrong");
   a_jmp: assert property (p_jmp) else $error("jump wrong");
   a_or: assert property (p_or) else $error("or wrong");
   a_skf: assert property (p_skf) else $error("skip op moved flag");
   a_inz: assert property (p_inz) else $error("inc flag wrong");
   a_one: assert property (p_one) else $error("pc step wrong");
   a_skp: assert property (p_skp) else $error("skip pc wrong");
   a_ret: assert property (p_ret) else $error("no retire");
   a_bsy: assert property (p_bsy) else $error("flush wrong");
endmodule : cise_core_assertions
bind cise_core cise_core_assertions chk_u (.mclk, .srst, .instr_valid, .instr_op, .instr_dest, .instr_literal,
   .program_counter_upper_latch, .acc, .zero_flag, .program_counter, .busy, .retire);

// File: cise_exec_if.sv
`timescale 1ns/1ps
`include "cise_consts.svh"
interface cise_exec_if;
   cise_pkg::cise_op_t            op;
   logic [`CISE_DATA_W-1:0]       file_val;
   logic [`CISE_DATA_W-1:0]       acc_val;
   logic [`CISE_LIT_W-1:0]        literal;
   logic                          dest;
   logic [`CISE_DATA_W-1:0]       result;
   logic                          wr_acc;
   logic                          wr_file;
   logic                          zero_en;
   logic                          zero_val;
   logic                          skip;
   logic                          jump;

   modport alu (
      input  op, file_val, acc_val, literal, dest,
      output result, wr_acc, wr_file, zero_en, zero_val, skip, jump
   );
   modport core (
      output op, file_val, acc_val, literal, dest,
      input  result, wr_acc, wr_file, zero_en, zero_val, skip, jump
   );
endinterface : cise_exec_if

// File: cise_pkg.sv
`include "cise_consts.svh"
package cise_pkg;
   typedef enum logic [`CISE_OP_W-1:0] {
      OP_NOP,
      OP_CLR_ACC,
      OP_DEC_SKZ,
      OP_INC_SKZ,
      OP_JUMP,
      OP_OR_LIT,
      OP_INC_F
   } cise_op_t;

   typedef enum logic {
      ST_EXEC,
      ST_FLUSH
   } cise_state_t;

   function automatic logic cise_is_zero(input logic [`CISE_DATA_W-1:0] v);
      cise_is_zero = (v == `CISE_CLR_VAL);
   endfunction : cise_is_zero
endpackage : cise_pkg

// File: tb.sv
`timescale 1ns/1ps
module tb;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic        ivld = 1'b0;
   logic [2:0]  iop = 3'h0;
   logic [6:0]  ia = 7'h00;
   logic        id = 1'b0;
   logic [10:0] il = 11'h000;
   logic [6:0]  lat = 7'h00;
   logic [7:0]  pk, acc, am, v;
   logic        zf, busy, ret, zm, sk;
   logic [14:0] pc, pcm;
   logic [7:0]  fm [128];
   logic [31:0] rnd = 32'h0EC4;
   int          num_errors = 0;
   int          n_checks = 0;
   always #4 mclk = ~mclk;
   cise_core dut_u (.mclk(mclk), .srst(srst), .instr_valid(ivld), .instr_op(iop), .instr_file_addr(ia),
      .instr_dest(id), .instr_literal(il), .program_counter_upper_latch(lat), .peek_addr(ia),
      .peek_data(pk), .acc(acc), .zero_flag(zf), .program_counter(pc), .busy(busy), .retire(ret));
   function automatic logic [31:0] nx(input logic [31:0] s);
      nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nx
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR t=%0t seen=%0h exp=%0h", $time, s, e);
      end
   endtask : chk
   task automatic wrap_up();
      if (num_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up
   task automatic exec(input logic [31:0] r);
      @(posedge mclk);
      ivld <= 1'b1;
      iop <= r[2:0];
      ia <= r[12] ? 7'h7F : {5'h00, r[4:3]};
      id <= r[5];
      il <= r[23:13];
      lat <= r[30:24];
      @(posedge mclk);
      sk = 1'b0;
      v = fm[ia];
      pcm = pcm + 15'h0001;
      case (iop)
         3'h1: begin
            am = 8'h00;
            zm = 1'b1;
         end
         3'h2, 3'h3, 3'h6: begin
            v = (iop == 3'h2) ? v - 8'h01 : v + 8'h01;
            if (id) fm[ia] = v;
            else am = v;
            if (iop == 3'h6) zm = (v == 8'h00);
            else sk = (v == 8'h00);
            if (sk) pcm = pcm + 15'h0001;
         end
         3'h4: begin
            pcm = {lat[6:3], il};
            sk = 1'b1;
         end
         3'h5: begin
            am = am | il[7:0];
            zm = (am == 8'h00);
         end
         default: ;
      endcase
      // a clear held in the flush slot must be dropped
      ivld <= sk;
      iop <= 3'h1;
      #1;
      chk(acc, am);
      chk(zf, zm);
      chk(pc, pcm);
      chk(busy, sk);
      chk(ret, 1);
      if (sk) begin
         @(posedge mclk);
         ivld <= 1'b0;
         #1;
         chk(acc, am);
         chk(busy, 0);
         chk(zf, zm);
         chk(pc, pcm);
         chk(ret, 0);
      end
      repeat (2) @(posedge mclk);
      #1;
      chk(pk, fm[ia]);
   endtask : exec
   initial begin
      am = 8'h00;
      zm = 1'b0;
      pcm = 15'h0000;
      foreach (fm[i]) fm[i] = 8'h00;
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      repeat (300) begin
         rnd = nx(rnd);
         exec(rnd);
      end
      wrap_up();
   end
   initial begin
      repeat (4000) @(posedge mclk);
      num_errors++;
      wrap_up();
   end
endmodule : tb
